// ===== verif/pin_watch.sv
// partner: board logic counting rising edges of the status pin
// assumes: pin is synchronous to clk_sys_in
`timescale 1ns/1ps
module pin_watch (
  // clock and clear
  input  wire logic       clk_sys_in,
  input  wire logic       clr_in,
  // status pin and count
  input  wire logic       pin_in,
  output logic      [7:0] rises_out
);
  logic last_q;
  always_ff @(posedge clk_sys_in) begin
    last_q <= pin_in;
    if (clr_in)
      rises_out <= 8'h00;
    else if (pin_in && !last_q)
      rises_out <= rises_out + 8'h01;
  end
endmodule

// ===== verif/stat_ref_ctrl_chk.sv
// checker: assertions at the ports of stat_ref_ctrl
// assumes: bound by name, one clock domain, shadows of written fields
`timescale 1ns/1ps
module stat_ref_chk
  import stat_ref_pkg::*;
(
  // clock, reset, register port
  input wire logic       clk_sys_in,
  input wire logic       rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // sources
  input wire logic       pri_signal_loss_in,
  input wire logic       pll1_lock_loss_in,
  input wire logic       test_override_in,
  input wire logic       test_level_in,
  // outputs
  input wire logic       second_status_pin_out,
  input wire logic       irq_out,
  input wire logic       pri_input_valid_out
);
  logic [7:0] sc_q;
  logic [5:0] mk_q;
  logic [2:0] cnt;
  logic       byp_q;
  logic       ok;
  logic       src;
  logic       kn;
  // -------------------------------------------
  // shadows and settle counter
  // -------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sc_q  <= 8'h28;
      mk_q  <= 6'h00;
      byp_q <= 1'b0;
      cnt   <= 3'h0;
    end else begin
      if (cnt != 3'h6)
        cnt <= cnt + 3'h1;
      if (reg_wr_in && reg_addr_in == STAT_CTRL_OFFSET)
        sc_q <= reg_wdata_in & 8'hF8;
      if (reg_wr_in && reg_addr_in == REF_CTRL_OFFSET)
        byp_q <= reg_wdata_in[7];
      if (reg_wr_in && reg_addr_in == IRQ_MASK_OFFSET)
        mk_q <= reg_wdata_in[5:0];
    end
  end
  always_comb begin
    ok  = (cnt == 3'h6);
    kn  = 1'b1;
    src = 1'b0;
    case (sc_q[7:4])
      4'h0: src = pri_signal_loss_in;
      4'h2: src = pll1_lock_loss_in;
      4'hA: src = irq_out;
      default: kn = 1'b0;
    endcase
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_read_idle:
    assert property (ok && !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not idle");
  a_read_stat:
    assert property (ok && $past(reg_rd_in && reg_addr_in == STAT_CTRL_OFFSET)
      |-> reg_rdata_out == $past(sc_q)) else $error("status ctrl read");
  a_read_unmapped:
    assert property (ok && $past(reg_rd_in && (reg_addr_in < 8'h1C ||
      reg_addr_in > 8'h1F)) |-> reg_rdata_out == 8'h00)
    else $error("unmapped read");
  a_pin_select:
    assert property (ok && $past(kn && !test_override_in) |->
      second_status_pin_out == $past(~(src ^ sc_q[3])))
    else $error("pin select");
  a_test_override:
    assert property (ok && $past(test_override_in) |->
      second_status_pin_out == $past(test_level_in)) else $error("override");
  a_pri_valid:
    assert property (ok |->
      pri_input_valid_out == $past(byp_q || !pri_signal_loss_in))
    else $error("primary valid");
  a_irq_masked:
    assert property (ok && mk_q == 6'h00 && $past(mk_q) == 6'h00 |-> !irq_out)
    else $error("masked irq");
  a_irq_event:
    assert property (ok && $rose(pll1_lock_loss_in) && mk_q[2] |->
      ##[1:2] irq_out) else $error("irq event");
endmodule
bind stat_ref_ctrl stat_ref_chk chk_u (
  .clk_sys_in            (clk_sys_in),
  .rstn_in               (rstn_in),
  .reg_addr_in           (reg_addr_in),
  .reg_wdata_in          (reg_wdata_in),
  .reg_wr_in             (reg_wr_in),
  .reg_rd_in             (reg_rd_in),
  .reg_rdata_out         (reg_rdata_out),
  .pri_signal_loss_in    (pri_signal_loss_in),
  .pll1_lock_loss_in     (pll1_lock_loss_in),
  .test_override_in      (test_override_in),
  .test_level_in         (test_level_in),
  .second_status_pin_out (second_status_pin_out),
  .irq_out               (irq_out),
  .pri_input_valid_out   (pri_input_valid_out)
);

// ===== verif/stat_ref_ctrl_tb.sv
// testbench: register, source and divider scenarios for stat_ref_ctrl
// assumes: pin_watch and the bound checker are compiled with it
`timescale 1ns/1ps
module stat_ref_ctrl_tb;
  import stat_ref_pkg::*;
  logic       clk_sys_in, rstn_in, wr, rd, ovr, tl, clr;
  logic [7:0] ad, wd, rdata, rises;
  logic [8:0] lv;
  logic [5:0] pv;
  logic [3:0] bv;
  logic       pin, irq, pval, sval;
  wire  [5:0] tout;
  int         errors = 0, comparisons = 0, cyc = 0;
  stat_ref_ctrl dut_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(ad),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .pri_signal_loss_in(lv[0]),
    .sec_signal_loss_in(lv[1]), .pll1_lock_loss_in(lv[2]),
    .pll2_lock_loss_in(lv[3]), .pll1_cal_active_in(lv[4]),
    .pll2_cal_active_in(lv[5]), .eeprom_active_in(lv[6]),
    .pll1_switchback_in(lv[7]), .pll2_switchback_in(lv[8]),
    .pll1_rdiv_pulse_in(pv[0]), .pll2_rdiv_pulse_in(pv[1]),
    .pll1_ndiv_pulse_in(pv[2]), .pll2_ndiv_pulse_in(pv[3]),
    .pll1_mdiv_pulse_in(pv[4]), .pll2_mdiv_pulse_in(pv[5]),
    .pll1_rdiv_bypass_in(bv[0]), .pll2_rdiv_bypass_in(bv[1]),
    .pll1_mdiv_bypass_in(bv[2]), .pll2_mdiv_bypass_in(bv[3]),
    .test_override_in(ovr), .test_level_in(tl),
    .second_status_pin_out(pin), .irq_out(irq),
    .pri_input_valid_out(pval), .sec_input_valid_out(sval),
    .sec_ground_termination_out(tout[5]),
    .pri_ground_termination_out(tout[4]),
    .sec_diff_termination_out(tout[3]),
    .pri_diff_termination_out(tout[2]),
    .sec_ac_bias_enable_out(tout[1]), .pri_ac_bias_enable_out(tout[0])
  );
  pin_watch watch_u (.clk_sys_in(clk_sys_in), .clr_in(clr),
    .pin_in(pin), .rises_out(rises));
  // -------------------------------------------
  // bus and compare tasks
  // -------------------------------------------
  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_sys_in);
    pv <= m;
    @(posedge clk_sys_in);
    pv <= 6'h00;
  endtask
  task automatic setlv(input logic [8:0] v);
    @(posedge clk_sys_in);
    lv <= v;
    tick(2);
  endtask
  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  task automatic t_reset();
    rdc(STAT_CTRL_OFFSET, 8'h28);
    rdc(REF_CTRL_OFFSET, 8'h06);
    chk({2'h0, tout}, 8'h06);
    chk({6'h00, pval, sval}, 8'h03);
  endtask
  task automatic t_regs();
    wrr(STAT_CTRL_OFFSET, 8'hFF);
    rdc(STAT_CTRL_OFFSET, 8'hF8);
    wrr(REF_CTRL_OFFSET, 8'h7F);
    rdc(REF_CTRL_OFFSET, 8'h3F);
    chk({2'h0, tout}, 8'h3F);
    @(posedge clk_sys_in);
    wd <= 8'h29;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk(rdata, 8'h29);
    tick(2);
    chk({2'h0, tout}, 8'h29);
    wrr(8'h20, 8'hFF);
    rdc(8'h20, 8'h00);
  endtask
  task automatic t_lvl();
    logic [3:0] lc [9] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9,
                           4'hD, 4'hE, 4'hF};
    for (int i = 0; i < 9; i++) begin
      for (int p = 0; p < 2; p++) begin
        wrr(STAT_CTRL_OFFSET, {lc[i], p[0], 3'h0});
        setlv(9'h001 << i);
        chk(pin, p[0]);
        setlv(~(9'h001 << i));
        chk(pin, !p[0]);
      end
    end
  endtask
  task automatic t_div();
    logic [3:0] dc [6] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'hB, 4'hC};
    int         pi [6] = '{0, 2, 1, 3, 4, 5};
    int         bi [6] = '{0, 9, 1, 9, 2, 3};
    for (int i = 0; i < 6; i++) begin
      wrr(STAT_CTRL_OFFSET, {dc[i], 4'h8});
      tick(3);
      @(posedge clk_sys_in);
      clr <= 1'b1;
      @(posedge clk_sys_in);
      clr <= 1'b0;
      pulse(6'h01 << ((pi[i] + 1) % 6));
      repeat (4) pulse(6'h01 << pi[i]);
      tick(3);
      chk(rises, 8'h02);
      if (bi[i] < 9) begin
        @(posedge clk_sys_in);
        bv <= 4'h1 << bi[i];
        tick(3);
        chk(pin, 1'b0);
        pulse(6'h01 << pi[i]);
        tick(3);
        chk(pin, 1'b0);
        @(posedge clk_sys_in);
        bv <= 4'h0;
      end
    end
  endtask
  task automatic t_irq();
    setlv(9'h000);
    wrr(IRQ_STATUS_OFFSET, 8'h3F);
    wrr(IRQ_MASK_OFFSET, 8'h04);
    wrr(STAT_CTRL_OFFSET, 8'hA8);
    rdc(IRQ_STATUS_OFFSET, 8'h00);
    setlv(9'h006);
    chk(irq, 1'b1);
    chk(pin, 1'b1);
    rdc(IRQ_STATUS_OFFSET, 8'h06);
    wrr(IRQ_STATUS_OFFSET, 8'h04);
    tick(1);
    chk(irq, 1'b0);
    chk(pin, 1'b0);
    rdc(IRQ_STATUS_OFFSET, 8'h02);
    setlv(9'h000);
  endtask
  task automatic t_ovr();
    wrr(STAT_CTRL_OFFSET, 8'h20);
    @(posedge clk_sys_in);
    ovr <= 1'b1;
    tl  <= 1'b1;
    setlv(9'h004);
    chk(pin, 1'b1);
    @(posedge clk_sys_in);
    tl <= 1'b0;
    setlv(9'h000);
    chk(pin, 1'b0);
    @(posedge clk_sys_in);
    ovr <= 1'b0;
    tick(2);
    chk(pin, 1'b1);
  endtask
  task automatic t_byp();
    wrr(IRQ_STATUS_OFFSET, 8'h3F);
    wrr(REF_CTRL_OFFSET, 8'h86);
    wrr(STAT_CTRL_OFFSET, 8'h08);
    setlv(9'h003);
    chk({5'h00, pval, sval, pin}, 8'h07);
    rdc(IRQ_STATUS_OFFSET, 8'h03);
    wrr(REF_CTRL_OFFSET, 8'h06);
    tick(2);
    chk({6'h00, pval, sval}, 8'h00);
  endtask
  // -------------------------------------------
  // clock, timeout and main sequence
  // -------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      results();
    end
  end
  initial begin
    {rstn_in, wr, rd, ovr, tl, clr} = 6'h00;
    ad = 8'h00;
    wd = 8'h00;
    lv = 9'h000;
    pv = 6'h00;
    bv = 4'h0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    tick(4);
    t_reset();
    t_regs();
    t_lvl();
    t_div();
    t_irq();
    t_ovr();
    t_byp();
    results();
  end
endmodule

// ===== verilog/div_toggle.sv
// holds: six divide-by-two toggles for divider pulse outputs
// assumes: pulse inputs are one-cycle strobes synchronous to clk_sys_in
`timescale 1ns/1ps
module div_toggle (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // divider pulses
  input  wire logic [5:0] pulse_in,
  // halved outputs
  output logic      [5:0] half_out
);

  typedef struct packed {
    logic [5:0] half;
  } tog_state_t;

  tog_state_t st_reg;
  tog_state_t st_next;

  // -------------------------------------------------------------------
  // toggle on each pulse
  // -------------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.half = st_reg.half ^ pulse_in;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign half_out = st_reg.half;

endmodule

// ===== verilog/stat_ref_ctrl.sv
// holds: second status pin select and reference input control registers
// assumes: 8-bit register port, status sources synchronous to clk_sys_in
//
// Overview of operation
// - Indicator select field in bits 7..4 resets to 0x2.
// - Codes 0x0 and 0x1 show primary and secondary loss of signal.
// - Codes 0x2 and 0x5 show lock loss of the first and second PLL.
// - Codes 0x3 and 0x6 show halved reference divider, only unbypassed.
// - Codes 0x4 and 0x7 show the halved feedback divider outputs.
// - Codes 0x8 and 0x9 show VCO calibration in progress per PLL.
// - Codes 0xB and 0xC show halved input divider, only unbypassed.
// - 0xA interrupt, 0xD EEPROM activity, 0xE and 0xF switchback.
// - Polarity bit 3 resets to 1; one is active high, zero active low.
// - Test configuration drive of the pin overrides the selection.
// - Detector bypass bit 7 makes both inputs valid to PLL control.
// - Detector bypass leaves interrupt flags and status pin untouched.
// - Bits 5 and 4 enable 50 ohm ground termination sec and pri.
// - Bits 3 and 2 enable 100 ohm differential termination.
// - Bits 1 and 0 enable internal AC coupling bias sec and pri.
// - Interrupt indication derives from the interrupt flag bits.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module stat_ref_ctrl
  import stat_ref_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // detector and pll status
  input  wire logic       pri_signal_loss_in,
  input  wire logic       sec_signal_loss_in,
  input  wire logic       pll1_lock_loss_in,
  input  wire logic       pll2_lock_loss_in,
  input  wire logic       pll1_cal_active_in,
  input  wire logic       pll2_cal_active_in,
  input  wire logic       eeprom_active_in,
  input  wire logic       pll1_switchback_in,
  input  wire logic       pll2_switchback_in,
  // divider pulses and bypass
  input  wire logic       pll1_rdiv_pulse_in,
  input  wire logic       pll2_rdiv_pulse_in,
  input  wire logic       pll1_ndiv_pulse_in,
  input  wire logic       pll2_ndiv_pulse_in,
  input  wire logic       pll1_mdiv_pulse_in,
  input  wire logic       pll2_mdiv_pulse_in,
  input  wire logic       pll1_rdiv_bypass_in,
  input  wire logic       pll2_rdiv_bypass_in,
  input  wire logic       pll1_mdiv_bypass_in,
  input  wire logic       pll2_mdiv_bypass_in,
  // test override
  input  wire logic       test_override_in,
  input  wire logic       test_level_in,
  // status pin and interrupt
  output logic            second_status_pin_out,
  output logic            irq_out,
  // reference input controls
  output logic            pri_input_valid_out,
  output logic            sec_input_valid_out,
  output logic            sec_ground_termination_out,
  output logic            pri_ground_termination_out,
  output logic            sec_diff_termination_out,
  output logic            pri_diff_termination_out,
  output logic            sec_ac_bias_enable_out,
  output logic            pri_ac_bias_enable_out
);

  typedef struct packed {
    logic [3:0] indicator_select;
    logic       indicator_polarity;
    logic [7:0] ref_ctrl;
    logic [5:0] irq_status;
    logic [5:0] irq_mask;
    logic [5:0] ev_prev;
    logic [7:0] rdata;
    logic       pin;
    logic       pri_valid;
    logic       sec_valid;
  } ctrl_state_t;

  ctrl_state_t st_reg;
  ctrl_state_t st_next;
  logic [5:0]  half;
  logic        rstn_sync;
  logic [5:0]  ev_now;
  logic        interrupt_indication_ind;
  logic        sel_level;
  logic        rst_meta_reg;
  logic        rst_sync_reg;

  // -------------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------------
  // kept apart from the state struct: it runs on the pin reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rstn_sync = rst_sync_reg;

  // -------------------------------------------------------------------
  // halved divider outputs
  // -------------------------------------------------------------------
  div_toggle u_div_toggle (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_sync),
    .pulse_in   ({pll2_mdiv_pulse_in, pll1_mdiv_pulse_in,
                  pll2_ndiv_pulse_in, pll1_ndiv_pulse_in,
                  pll2_rdiv_pulse_in, pll1_rdiv_pulse_in}),
    .half_out   (half)
  );

  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input ctrl_state_t s);
    logic [7:0] r;
    r = 8'h00;
    // reserved bits zero
    // reserved read zero
    if (a == STAT_CTRL_OFFSET) begin
      r[SEL_MSB:SEL_LSB] = s.indicator_select;
      r[POL_BIT]         = s.indicator_polarity;
    end else if (a == REF_CTRL_OFFSET) begin
      r = s.ref_ctrl & REF_WR_MASK;
    end else if (a == IRQ_STATUS_OFFSET) begin
      r = {2'h0, s.irq_status};
    end else if (a == IRQ_MASK_OFFSET) begin
      r = {2'h0, s.irq_mask};
    end
    return r;
  endfunction

  // unmasked flag pending
  function automatic logic irq_pending(input ctrl_state_t s);
    return |(s.irq_status & s.irq_mask);
  endfunction

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;

    // real detector results feed events
    // bypass leaves flags
    ev_now = {pll2_switchback_in, pll1_switchback_in,
              pll2_lock_loss_in, pll1_lock_loss_in,
              sec_signal_loss_in, pri_signal_loss_in};
    st_next.ev_prev = ev_now;

    // register writes
    if (reg_wr_in) begin
      if (reg_addr_in == STAT_CTRL_OFFSET) begin
        st_next.indicator_select   = reg_wdata_in[SEL_MSB:SEL_LSB];
        st_next.indicator_polarity = reg_wdata_in[POL_BIT];
      end else if (reg_addr_in == REF_CTRL_OFFSET) begin
        st_next.ref_ctrl = reg_wdata_in & REF_WR_MASK;
      end else if (reg_addr_in == IRQ_STATUS_OFFSET) begin
        st_next.irq_status = st_reg.irq_status & ~reg_wdata_in[5:0];
      end else if (reg_addr_in == IRQ_MASK_OFFSET) begin
        st_next.irq_mask = reg_wdata_in[5:0];
      end
    end
    // rising edges set flags, set beats clear
    st_next.irq_status = st_next.irq_status | (ev_now & ~st_reg.ev_prev);

    // read data one cycle later
    st_next.rdata = reg_rd_in ? read_mux(reg_addr_in, st_reg) : 8'h00;

    interrupt_indication_ind = irq_pending(st_reg);

    // indicator selection
    case (indicator_select_code_t'(st_reg.indicator_select))
      SEL_PRI_LOS: sel_level = pri_signal_loss_in;
      SEL_SEC_LOS: sel_level = sec_signal_loss_in;
      SEL_LOL1:    sel_level = pll1_lock_loss_in;
      SEL_LOL2:    sel_level = pll2_lock_loss_in;
      SEL_RDIV1:   sel_level = half[0] & ~pll1_rdiv_bypass_in;
      SEL_RDIV2:   sel_level = half[1] & ~pll2_rdiv_bypass_in;
      SEL_NDIV1:   sel_level = half[2];
      SEL_NDIV2:   sel_level = half[3];
      SEL_CAL1:    sel_level = pll1_cal_active_in;
      SEL_CAL2:    sel_level = pll2_cal_active_in;
      SEL_MDIV1:   sel_level = half[4] & ~pll1_mdiv_bypass_in;
      SEL_MDIV2:   sel_level = half[5] & ~pll2_mdiv_bypass_in;
      SEL_INTERRUPT_INDICATION:    sel_level = interrupt_indication_ind;
      SEL_EEPROM:  sel_level = eeprom_active_in;
      SEL_SW1:     sel_level = pll1_switchback_in;
      default:     sel_level = pll2_switchback_in;
    endcase

    if (test_override_in) begin
      st_next.pin = test_level_in;
    end else begin
      st_next.pin = st_reg.indicator_polarity ? sel_level : ~sel_level;
    end

    st_next.pri_valid = st_reg.ref_ctrl[BYP_BIT] | ~pri_signal_loss_in;
    st_next.sec_valid = st_reg.ref_ctrl[BYP_BIT] | ~sec_signal_loss_in;
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_sync) begin
    if (!rstn_sync) begin
      st_reg.indicator_select   <= SEL_RESET;
      st_reg.indicator_polarity <= POL_RESET;
      st_reg.ref_ctrl           <= REF_RESET;
      st_reg.irq_status         <= EV_RESET;
      st_reg.irq_mask           <= EV_RESET;
      st_reg.ev_prev            <= EV_RESET;
      st_reg.rdata              <= 8'h00;
      st_reg.pin                <= 1'b0;
      st_reg.pri_valid          <= 1'b0;
      st_reg.sec_valid          <= 1'b0;
    end else begin
      st_reg.indicator_select   <= st_next.indicator_select;
      st_reg.indicator_polarity <= st_next.indicator_polarity;
      st_reg.ref_ctrl           <= st_next.ref_ctrl;
      st_reg.irq_status         <= st_next.irq_status;
      st_reg.irq_mask           <= st_next.irq_mask;
      st_reg.ev_prev            <= st_next.ev_prev;
      st_reg.rdata              <= st_next.rdata;
      st_reg.pin                <= st_next.pin;
      st_reg.pri_valid          <= st_next.pri_valid;
      st_reg.sec_valid          <= st_next.sec_valid;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign reg_rdata_out         = st_reg.rdata;
  assign second_status_pin_out = st_reg.pin;
  assign irq_out               = irq_pending(st_reg);
  assign pri_input_valid_out   = st_reg.pri_valid;
  assign sec_input_valid_out   = st_reg.sec_valid;
  assign sec_ground_termination_out = st_reg.ref_ctrl[SEC_GND_BIT];
  assign pri_ground_termination_out = st_reg.ref_ctrl[PRI_GND_BIT];
  assign sec_diff_termination_out   = st_reg.ref_ctrl[SEC_DIFF_BIT];
  assign pri_diff_termination_out   = st_reg.ref_ctrl[PRI_DIFF_BIT];
  assign sec_ac_bias_enable_out     = st_reg.ref_ctrl[SEC_AC_BIT];
  assign pri_ac_bias_enable_out     = st_reg.ref_ctrl[PRI_AC_BIT];

endmodule

// ===== verilog/stat_ref_pkg.sv
// package: offsets, field layout, reset values for status pin select and
// reference input control block
// assumes: 8-bit register port, single clock domain
package stat_ref_pkg;

  // register offsets
  localparam logic [7:0] STAT_CTRL_OFFSET  = 8'h1C;
  localparam logic [7:0] REF_CTRL_OFFSET   = 8'h1D;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h1E;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h1F;

  // status control fields
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 4;
  localparam int POL_BIT = 3;
  localparam logic [3:0] SEL_RESET = 4'h2;
  localparam logic       POL_RESET = 1'h1;

  // reference input control fields
  localparam int BYP_BIT      = 7;
  localparam int SEC_GND_BIT  = 5;
  localparam int PRI_GND_BIT  = 4;
  localparam int SEC_DIFF_BIT = 3;
  localparam int PRI_DIFF_BIT = 2;
  localparam int SEC_AC_BIT   = 1;
  localparam int PRI_AC_BIT   = 0;
  localparam logic [7:0] REF_RESET    = 8'h06;
  localparam logic [7:0] REF_WR_MASK  = 8'hBF;

  // event status layout
  localparam int EV_PRI_LOS = 0;
  localparam int EV_SEC_LOS = 1;
  localparam int EV_LOL1    = 2;
  localparam int EV_LOL2    = 3;
  localparam int EV_SW1     = 4;
  localparam int EV_SW2     = 5;
  localparam logic [5:0] EV_RESET = 6'h00;

  // indicator select codes
  typedef enum logic [3:0] {
    SEL_PRI_LOS  = 4'h0,
    SEL_SEC_LOS  = 4'h1,
    SEL_LOL1     = 4'h2,
    SEL_RDIV1    = 4'h3,
    SEL_NDIV1    = 4'h4,
    SEL_LOL2     = 4'h5,
    SEL_RDIV2    = 4'h6,
    SEL_NDIV2    = 4'h7,
    SEL_CAL1     = 4'h8,
    SEL_CAL2     = 4'h9,
    SEL_INTERRUPT_INDICATION     = 4'hA,
    SEL_MDIV1    = 4'hB,
    SEL_MDIV2    = 4'hC,
    SEL_EEPROM   = 4'hD,
    SEL_SW1      = 4'hE,
    SEL_SW2      = 4'hF
  } indicator_select_code_t;

endpackage
